// ===== design/gpio_port_pkg.sv
// constants shared by the parallel port block: register map, reset values,
// field positions and per-port bit masks.
// assumes a 32-bit AXI4-Lite register bus with byte addresses below 8'h40.
package gpio_port_pkg;

  localparam int NPORT  = 3;  // 0: wide port, 1: mixed port, 2: nibble port
  localparam int SYNC_W = 28; // wide 8 + mixed 8 + nibble 4 + input-only 8

  // per-port register offsets: data, configuration, pin levels
  localparam logic [7:0] DATA_OFF [NPORT] = '{8'h00, 8'h0C, 8'h18};
  localparam logic [7:0] CFG_OFF  [NPORT] = '{8'h04, 8'h10, 8'h1C};
  localparam logic [7:0] PIN_OFF  [NPORT] = '{8'h08, 8'h14, 8'h20};

  localparam logic [7:0] OUT_DATA_OFF   = 8'h24;
  localparam logic [7:0] IN_PIN_OFF     = 8'h28;
  localparam logic [7:0] IRQ_STATUS_OFF = 8'h2C;
  localparam logic [7:0] IRQ_MASK_OFF   = 8'h30;
  localparam logic [7:0] OSC_CTRL_OFF   = 8'h34;
  localparam logic [7:0] ADDR_ALIGN     = 8'hFC;

  // implemented bits of data and configuration per port
  localparam logic [7:0] DAT_MASK [NPORT] = '{8'hFF, 8'hFF, 8'h0F};
  localparam logic [7:0] CFG_MASK [NPORT] = '{8'hFF, 8'h3F, 8'h0F};

  localparam logic [7:0] PORT_DAT_RESET = 8'h00;
  localparam logic [7:0] PORT_OEN_RESET = 8'hFF;
  localparam logic [7:0] OUT_PORT_RESET = 8'hFF;
  localparam logic [7:0] ZERO_BYTE      = 8'h00;

  // mixed-port bit positions of the alternate functions
  localparam int G_EXT_INT_BIT = 0;
  localparam int G_TIMER_BIT   = 3;
  localparam int G_SER_OUT_BIT = 4;
  localparam int G_SER_CLK_BIT = 5;
  localparam int G_SER_IN_BIT  = 6;
  localparam int G_HALT_BIT    = 7;
  localparam logic [7:0] G_HALT_MASK = 8'h80;

  // oscillator option codes (two option bits)
  localparam logic [1:0] OSC_CRYSTAL  = 2'h0;
  localparam logic [1:0] OSC_RC       = 2'h2;
  localparam logic [1:0] OSC_EXTERNAL = 2'h3;
  localparam logic [1:0] OSC_RESET    = 2'h0;

  // interrupt status bits
  localparam int ST_W        = 3;
  localparam int ST_EXT_INT  = 0;
  localparam int ST_HALT_IN  = 1;
  localparam int ST_RESTART  = 2;
  localparam logic [ST_W-1:0] ST_RESET = 3'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== design/pin_sync.sv
// two-stage synchroniser for all pin inputs of the port block.
// assumes pins are asynchronous to clk_in; only stage two is visible outside.
`timescale 1ns/1ns
module pin_sync
  import gpio_port_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic              ce_in,
  input  wire logic [SYNC_W-1:0] async_in,
  output logic      [SYNC_W-1:0] sync_out
);
  logic [SYNC_W-1:0] meta_q;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else if (ce_in) begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// ===== design/gpio_ports.sv
// parallel i/o ports of a small controller behind an AXI4-Lite slave:
// wide and nibble bidirectional ports, mixed port, output-only and input-only.
// assumes board logic resolves each pin from its out, oe_n and pull-up signals.
//
// How it works
// - wide/nibble bit: cfg,data pick hi-z/pull-up/low/high
// - mixed port bits 0-5 use the same encoding
// - mixed: six i/o, two input-only, all synchronised
// - config writes to mixed bits 6,7 ignored
// - mixed config bits 6,7 read zero
// - writing mixed data bit 7 enters halt
// - halt stops clock for rc/crystal options
// - wide, mixed, nibble port: data, config, pin-read locations
// - nibble port: bits 4-7 not implemented
// - output-only port forced high during reset
// - input-only port reads pin levels
// - mixed bits carry alternate-function taps
// - reset clears port data and config
// - non-crystal option: bit 7 input, halt restart
`timescale 1ns/1ns
module gpio_ports
  import gpio_port_pkg::*;
(
  input  wire logic        CLK_IN,
  input  wire logic        RST_IN,
  input  wire logic        CE_IN,
  input  wire logic [7:0]  AWADDR_IN,
  input  wire logic        AWVALID_IN,
  output logic             AWREADY_OUT,
  input  wire logic [31:0] WDATA_IN,
  input  wire logic [3:0]  WSTRB_IN,
  input  wire logic        WVALID_IN,
  output logic             WREADY_OUT,
  output logic [1:0]       BRESP_OUT,
  output logic             BVALID_OUT,
  input  wire logic        BREADY_IN,
  input  wire logic [7:0]  ARADDR_IN,
  input  wire logic        ARVALID_IN,
  output logic             ARREADY_OUT,
  output logic [31:0]      RDATA_OUT,
  output logic [1:0]       RRESP_OUT,
  output logic             RVALID_OUT,
  input  wire logic        RREADY_IN,
  input  wire logic [7:0]  L_PIN_IN,
  output logic [7:0]       L_PIN_OUT,
  output logic [7:0]       L_PIN_OE_N_OUT,
  output logic [7:0]       L_PULLUP_OUT,
  input  wire logic [7:0]  G_PIN_IN,
  output logic [7:0]       G_PIN_OUT,
  output logic [7:0]       G_PIN_OE_N_OUT,
  output logic [7:0]       G_PULLUP_OUT,
  input  wire logic [3:0]  C_PIN_IN,
  output logic [3:0]       C_PIN_OUT,
  output logic [3:0]       C_PIN_OE_N_OUT,
  output logic [3:0]       C_PULLUP_OUT,
  output logic [7:0]       D_PIN_OUT,
  input  wire logic [7:0]  I_PIN_IN,
  output logic             EXTERNAL_INTERRUPT_INPUT_OUT,
  output logic             TIMER_IO_PIN_OUT,
  output logic             SERIAL_DATA_PIN_OUT,
  output logic             SERIAL_SHIFT_CLOCK_OUT,
  output logic             SERIAL_INPUT_PIN_OUT,
  output logic             HALT_CONTROL_BIT_OUT,
  output logic             CLOCK_INPUT_STOP_OUT,
  output logic             OSCILLATOR_OUTPUT_EN_OUT,
  output logic             IRQ_OUT
);
  import gpio_port_pkg::*;

  // bus slave state
  logic            aw_rdy_q;
  logic            w_rdy_q;
  logic            b_vld_q;
  logic [1:0]      b_resp_q;
  logic [7:0]      aw_addr_q;
  logic [7:0]      w_data_q;
  logic            w_stb_q;
  logic            ar_rdy_q;
  logic            r_vld_q;
  logic [1:0]      r_resp_q;
  logic [31:0]     r_data_q;

  // port state, index as in the package
  logic [7:0]      dat_q [NPORT];
  logic [7:0]      oen_q [NPORT];
  logic [7:0]      pu_q  [NPORT];
  logic [7:0]      dat_d [NPORT];
  logic [7:0]      oen_d [NPORT];
  logic [7:0]      pin_v [NPORT];
  logic [7:0]      port_rd [NPORT];
  logic [NPORT-1:0] port_hit;

  logic [7:0]      out_q;
  logic [1:0]      osc_q;
  logic [ST_W-1:0] sts_q;
  logic [ST_W-1:0] mask_q;
  logic            irq_q;
  logic            clk_stop_q;
  logic            osc_en_q;
  logic            g7_prev_q;
  logic            int_prev_q;
  logic [SYNC_W-1:0] pin_s;

  pin_sync u_sync (
    .clk_in   (CLK_IN),
    .rst_in   (RST_IN),
    .ce_in    (CE_IN),
    .async_in ({I_PIN_IN, C_PIN_IN, G_PIN_IN, L_PIN_IN}),
    .sync_out (pin_s)
  );

  // write decode
  wire       wr_go    = ~aw_rdy_q & ~w_rdy_q & ~b_vld_q;
  wire       wr_en    = wr_go & w_stb_q;
  wire       we_out   = wr_en & (aw_addr_q == OUT_DATA_OFF);
  wire       we_sts   = wr_en & (aw_addr_q == IRQ_STATUS_OFF);
  wire       we_mask  = wr_en & (aw_addr_q == IRQ_MASK_OFF);
  wire       we_osc   = wr_en & (aw_addr_q == OSC_CTRL_OFF);

  // read decode; araddr is aligned to a word before compare
  wire [7:0] ar_addr  = ARADDR_IN & ADDR_ALIGN;
  wire       ar_go    = ARVALID_IN & ar_rdy_q;

  // pin levels as seen by software, unimplemented bits read zero
  assign pin_v[0] = pin_s[7:0];
  assign pin_v[1] = pin_s[15:8];
  assign pin_v[2] = {4'h0, pin_s[19:16]};
  wire [7:0] in_pins = pin_s[27:20];

  // halt: bit 7 of the mixed data register is the halt state itself
  wire       halt      = dat_q[1][G_HALT_BIT];
  wire       crystal   = ~osc_q[1];
  wire       g7_s      = pin_v[1][G_HALT_BIT];
  wire       restart   = halt & ~crystal & g7_s & ~g7_prev_q;
  wire       halt_wr   = wr_en & (aw_addr_q == DATA_OFF[1]) & w_data_q[G_HALT_BIT];
  wire       halt_set  = halt_wr & ~halt;
  // an edge is seen only if each phase spans a sample, which the source ensures
  wire       ext_int   = pin_v[1][G_EXT_INT_BIT];
  wire       int_edge  = ext_int & ~int_prev_q;

  wire [ST_W-1:0] ev = {restart, halt_set, int_edge};
  wire [ST_W-1:0] sts_clr = we_sts ? w_data_q[ST_W-1:0] : ST_RESET;
  // a new event wins over a clear in the same cycle
  wire [ST_W-1:0] sts_d = (sts_q & ~sts_clr) | ev;
  wire [ST_W-1:0] mask_d = we_mask ? w_data_q[ST_W-1:0] : mask_q;
  wire [1:0]      osc_d  = we_osc ? w_data_q[1:0] : osc_q;
  wire            halt_d = dat_d[1][G_HALT_BIT];

  genvar p;
  generate
    for (p = 0; p < NPORT; p++) begin : g_port
      wire we_dat = wr_en & (aw_addr_q == DATA_OFF[p]);
      wire we_cfg = wr_en & (aw_addr_q == CFG_OFF[p]);
      // restart only touches the halt bit of the mixed port
      wire [7:0] clr = (p == 1 && restart) ? G_HALT_MASK : ZERO_BYTE;

      assign dat_d[p] = ((we_dat ? w_data_q : dat_q[p]) & DAT_MASK[p]) & ~clr;
      // input-only and missing bits keep their enable off
      assign oen_d[p] = we_cfg ? ~(w_data_q & CFG_MASK[p]) : oen_q[p];

      // data, config and pin locations read back per port
      assign port_hit[p] = (ar_addr == DATA_OFF[p]) | (ar_addr == CFG_OFF[p])
                         | (ar_addr == PIN_OFF[p]);
      assign port_rd[p]  = ((ar_addr == DATA_OFF[p]) ? dat_q[p] : ZERO_BYTE)
                         | ((ar_addr == CFG_OFF[p]) ? (~oen_q[p] & CFG_MASK[p]) : ZERO_BYTE)
                         | ((ar_addr == PIN_OFF[p]) ? pin_v[p] : ZERO_BYTE);

      // drivers change only in the bits written and in mixed bit 7 on restart, all from flops
      always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
          dat_q[p] <= PORT_DAT_RESET;
          oen_q[p] <= PORT_OEN_RESET;
          pu_q[p]  <= PORT_DAT_RESET;
        end else if (CE_IN) begin
          dat_q[p] <= dat_d[p];
          oen_q[p] <= oen_d[p];
          pu_q[p]  <= oen_d[p] & dat_d[p];
        end
      end
    end
  endgenerate

  wire       misc_hit = (ar_addr == OUT_DATA_OFF) | (ar_addr == IN_PIN_OFF)
                      | (ar_addr == IRQ_STATUS_OFF) | (ar_addr == IRQ_MASK_OFF)
                      | (ar_addr == OSC_CTRL_OFF);
  wire [7:0] misc_rd  = ((ar_addr == OUT_DATA_OFF) ? out_q : ZERO_BYTE)
                      | ((ar_addr == IN_PIN_OFF) ? in_pins : ZERO_BYTE)
                      | ((ar_addr == IRQ_STATUS_OFF) ? {5'h0, sts_q} : ZERO_BYTE)
                      | ((ar_addr == IRQ_MASK_OFF) ? {5'h0, mask_q} : ZERO_BYTE)
                      | ((ar_addr == OSC_CTRL_OFF) ? {6'h00, osc_q} : ZERO_BYTE);
  wire       rd_hit   = (|port_hit) | misc_hit;
  wire [7:0] rd_val   = port_rd[0] | port_rd[1] | port_rd[2] | misc_rd;

  // write address and data are taken independently, answer after both
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      aw_rdy_q  <= 1'b1;
      w_rdy_q   <= 1'b1;
      b_vld_q   <= 1'b0;
      b_resp_q  <= RESP_OKAY;
      aw_addr_q <= ZERO_BYTE;
      w_data_q  <= ZERO_BYTE;
      w_stb_q   <= 1'b0;
    end else if (CE_IN) begin
      if (AWVALID_IN && aw_rdy_q) begin
        aw_rdy_q  <= 1'b0;
        aw_addr_q <= AWADDR_IN & ADDR_ALIGN;
      end
      if (WVALID_IN && w_rdy_q) begin
        w_rdy_q  <= 1'b0;
        w_data_q <= WDATA_IN[7:0];
        w_stb_q  <= WSTRB_IN[0];
      end
      if (wr_go) begin
        b_vld_q  <= 1'b1;
        b_resp_q <= (rd_wr_hit(aw_addr_q)) ? RESP_OKAY : RESP_SLVERR;
      end else if (b_vld_q && BREADY_IN) begin
        b_vld_q  <= 1'b0;
        aw_rdy_q <= 1'b1;
        w_rdy_q  <= 1'b1;
      end
    end
  end

  function automatic logic rd_wr_hit(input logic [7:0] a);
    rd_wr_hit = 1'b0;
    for (int i = 0; i < NPORT; i++) begin
      if (a == DATA_OFF[i] || a == CFG_OFF[i] || a == PIN_OFF[i]) begin
        rd_wr_hit = 1'b1;
      end
    end
    if (a == OUT_DATA_OFF || a == IN_PIN_OFF || a == IRQ_STATUS_OFF
        || a == IRQ_MASK_OFF || a == OSC_CTRL_OFF) begin
      rd_wr_hit = 1'b1;
    end
  endfunction

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ar_rdy_q <= 1'b1;
      r_vld_q  <= 1'b0;
      r_resp_q <= RESP_OKAY;
      r_data_q <= '0;
    end else if (CE_IN) begin
      if (ar_go) begin
        ar_rdy_q <= 1'b0;
        r_vld_q  <= 1'b1;
        r_resp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        r_data_q <= {24'h000000, rd_hit ? rd_val : ZERO_BYTE};
      end else if (r_vld_q && RREADY_IN) begin
        r_vld_q  <= 1'b0;
        ar_rdy_q <= 1'b1;
      end
    end
  end

  // output-only port, interrupt logic and clock control
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      out_q      <= OUT_PORT_RESET;
      osc_q      <= OSC_RESET;
      sts_q      <= ST_RESET;
      mask_q     <= ST_RESET;
      irq_q      <= 1'b0;
      clk_stop_q <= 1'b0;
      osc_en_q   <= 1'b0;
      g7_prev_q  <= 1'b0;
      int_prev_q <= 1'b0;
    end else if (CE_IN) begin
      out_q      <= we_out ? w_data_q : out_q;
      osc_q      <= osc_d;
      sts_q      <= sts_d;
      mask_q     <= mask_d;
      irq_q      <= |(sts_d & mask_d);
      clk_stop_q <= halt_d & (osc_d != OSC_EXTERNAL);
      osc_en_q   <= ~osc_d[1];
      g7_prev_q  <= g7_s;
      int_prev_q <= ext_int;
    end
  end

  assign AWREADY_OUT = aw_rdy_q;
  assign WREADY_OUT  = w_rdy_q;
  assign BVALID_OUT  = b_vld_q;
  assign BRESP_OUT   = b_resp_q;
  assign ARREADY_OUT = ar_rdy_q;
  assign RVALID_OUT  = r_vld_q;
  assign RRESP_OUT   = r_resp_q;
  assign RDATA_OUT   = r_data_q;

  assign L_PIN_OUT      = dat_q[0];
  assign L_PIN_OE_N_OUT = oen_q[0];
  assign L_PULLUP_OUT   = pu_q[0];
  assign G_PIN_OUT      = dat_q[1];
  assign G_PIN_OE_N_OUT = oen_q[1];
  assign G_PULLUP_OUT   = pu_q[1];
  assign C_PIN_OUT      = dat_q[2][3:0];
  assign C_PIN_OE_N_OUT = oen_q[2][3:0];
  assign C_PULLUP_OUT   = pu_q[2][3:0];
  assign D_PIN_OUT      = out_q;

  // alternate-function taps: pin taps are synchronised levels, halt, clock stop, oscillator and irq come from flops
  assign EXTERNAL_INTERRUPT_INPUT_OUT = pin_s[8 + G_EXT_INT_BIT];
  assign TIMER_IO_PIN_OUT             = pin_s[8 + G_TIMER_BIT];
  assign SERIAL_DATA_PIN_OUT          = pin_s[8 + G_SER_OUT_BIT];
  assign SERIAL_SHIFT_CLOCK_OUT       = pin_s[8 + G_SER_CLK_BIT];
  assign SERIAL_INPUT_PIN_OUT         = pin_s[8 + G_SER_IN_BIT];
  assign HALT_CONTROL_BIT_OUT         = dat_q[1][G_HALT_BIT];
  assign CLOCK_INPUT_STOP_OUT         = clk_stop_q;
  assign OSCILLATOR_OUTPUT_EN_OUT     = osc_en_q;
  assign IRQ_OUT                      = irq_q;
endmodule

// ===== verification/board_pins.sv
// board circuitry on one port: works out each pin level from all drivers.
// assumes the device drives a bit when its oe_n is low.
`timescale 1ns/1ns
module board_pins #(
  parameter int W = 8
) (
  input  wire logic         clk_in,
  input  wire logic [W-1:0] drv_in,
  input  wire logic [W-1:0] oe_n_in,
  input  wire logic [W-1:0] pullup_in,
  input  wire logic [W-1:0] ext_in,
  input  wire logic [W-1:0] ext_en_in,
  output logic      [W-1:0] pin_out
);
  // a floating bit toggles so it never reads as a lucky constant
  logic pat_q = 1'b0;
  always @(posedge clk_in) begin
    pat_q <= ~pat_q;
  end
  assign pin_out = (~oe_n_in & drv_in) | (oe_n_in & ext_en_in & ext_in)
                 | (oe_n_in & ~ext_en_in & (pullup_in | {W{pat_q}}));
endmodule

// ===== verification/gpio_ports_assertions.sv
// assertion checker for the parallel port block, seen from its top ports.
// assumes CE_IN low freezes the pin taps; bound from tb_top.
`timescale 1ns/1ns
module gpio_ports_checker (
  input wire logic       CLK_IN,
  input wire logic       RST_IN,
  input wire logic       CE_IN,
  input wire logic       BVALID_OUT,
  input wire logic [7:0] L_PIN_OUT,
  input wire logic [7:0] L_PIN_OE_N_OUT,
  input wire logic [7:0] L_PULLUP_OUT,
  input wire logic [7:0] G_PIN_IN,
  input wire logic [7:0] G_PIN_OE_N_OUT,
  input wire logic [7:0] G_PULLUP_OUT,
  input wire logic [7:0] D_PIN_OUT,
  input wire logic       EXTERNAL_INTERRUPT_INPUT_OUT,
  input wire logic       HALT_CONTROL_BIT_OUT,
  input wire logic       CLOCK_INPUT_STOP_OUT
);
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (RST_IN);

  property p_in_only;
    G_PIN_OE_N_OUT[7:6] == 2'b11;
  endproperty
  a_in_only: assert property (p_in_only) else $error("input-only pin driven");
  property p_pull;
    ((L_PULLUP_OUT & ~L_PIN_OE_N_OUT) | (G_PULLUP_OUT & ~G_PIN_OE_N_OUT)) == 8'h00;
  endproperty
  a_pull: assert property (p_pull) else $error("pull-up on a driven bit");
  property p_d_reset;
    $fell(RST_IN) |-> D_PIN_OUT == 8'hFF;
  endproperty
  a_d_reset: assert property (p_d_reset) else $error("output port not high");
  property p_port_reset;
    $fell(RST_IN) |-> (L_PIN_OE_N_OUT & G_PIN_OE_N_OUT) == 8'hFF
      && (L_PULLUP_OUT | G_PULLUP_OUT) == 8'h00;
  endproperty
  a_port_reset: assert property (p_port_reset) else $error("ports not hi-z");
  property p_halt;
    $rose(HALT_CONTROL_BIT_OUT) |-> $rose(BVALID_OUT);
  endproperty
  a_halt: assert property (p_halt) else $error("halt without a write");
  property p_stop;
    CLOCK_INPUT_STOP_OUT |-> HALT_CONTROL_BIT_OUT;
  endproperty
  a_stop: assert property (p_stop) else $error("clock stop outside halt");
  // restart clears data bit 7 by itself, so bit 7 is left out here
  property p_pin_write;
    !$stable({L_PIN_OUT, L_PIN_OE_N_OUT, L_PULLUP_OUT, G_PIN_OE_N_OUT, G_PULLUP_OUT[6:0]})
      |-> $rose(BVALID_OUT);
  endproperty
  a_pin_write: assert property (p_pin_write) else $error("pin change off a write");
  property p_tap;
    !$past(RST_IN) && !$past(RST_IN, 2) && $past(CE_IN) && $past(CE_IN, 2)
      |-> EXTERNAL_INTERRUPT_INPUT_OUT == $past(G_PIN_IN[0], 2);
  endproperty
  a_tap: assert property (p_tap) else $error("interrupt tap wrong");
endmodule

// ===== verification/tb_top.sv
// self-checking bench for the parallel port block with board pin models.
// assumes the pin models and the checker are compiled first.
`timescale 1ns/1ns
module tb_top;
  import gpio_port_pkg::*;
  logic        clk, rst, ce, awv, wv, brdy, arv, rrdy;
  logic [3:0]  strb;
  logic [7:0]  awa, ara, gx, gxe, ip;
  logic [31:0] wd;
  wire         awr, wrdy, bv, arr, rv, irq, halt, stop, osc, tint;
  wire         timer_io_pin, sdo, sck, sdi;
  wire  [1:0]  br, rr;
  wire  [31:0] rdat;
  wire  [7:0]  po[3], poe[3], ppu[3], lp, gp, dp;
  wire  [3:0]  co, coe, cpu, cp;
  int          failures = 0;
  int          num_checks = 0;
  assign po[2] = {4'h0, co};
  assign poe[2] = {4'hF, coe};
  assign ppu[2] = {4'h0, cpu};

  gpio_ports i_dut (.CLK_IN(clk), .RST_IN(rst), .CE_IN(ce), .AWADDR_IN(awa),
    .AWVALID_IN(awv), .AWREADY_OUT(awr), .WDATA_IN(wd), .WSTRB_IN(strb), .WVALID_IN(wv),
    .WREADY_OUT(wrdy), .BRESP_OUT(br), .BVALID_OUT(bv), .BREADY_IN(brdy), .ARADDR_IN(ara),
    .ARVALID_IN(arv), .ARREADY_OUT(arr), .RDATA_OUT(rdat), .RRESP_OUT(rr), .RVALID_OUT(rv),
    .RREADY_IN(rrdy), .L_PIN_IN(lp), .L_PIN_OUT(po[0]), .L_PIN_OE_N_OUT(poe[0]),
    .L_PULLUP_OUT(ppu[0]), .G_PIN_IN(gp), .G_PIN_OUT(po[1]), .G_PIN_OE_N_OUT(poe[1]),
    .G_PULLUP_OUT(ppu[1]), .C_PIN_IN(cp), .C_PIN_OUT(co), .C_PIN_OE_N_OUT(coe),
    .C_PULLUP_OUT(cpu), .D_PIN_OUT(dp), .I_PIN_IN(ip), .EXTERNAL_INTERRUPT_INPUT_OUT(tint),
    .TIMER_IO_PIN_OUT(timer_io_pin), .SERIAL_DATA_PIN_OUT(sdo), .SERIAL_SHIFT_CLOCK_OUT(sck),
    .SERIAL_INPUT_PIN_OUT(sdi), .HALT_CONTROL_BIT_OUT(halt), .CLOCK_INPUT_STOP_OUT(stop),
    .OSCILLATOR_OUTPUT_EN_OUT(osc), .IRQ_OUT(irq));
  board_pins #(.W(8)) i_lb (.clk_in(clk), .drv_in(po[0]), .oe_n_in(poe[0]),
    .pullup_in(ppu[0]), .ext_in(8'h00), .ext_en_in(8'h00), .pin_out(lp));
  board_pins #(.W(8)) i_gb (.clk_in(clk), .drv_in(po[1]), .oe_n_in(poe[1]),
    .pullup_in(ppu[1]), .ext_in(gx), .ext_en_in(gxe), .pin_out(gp));
  board_pins #(.W(4)) i_cb (.clk_in(clk), .drv_in(co), .oe_n_in(coe),
    .pullup_in(cpu), .ext_in(4'h0), .ext_en_in(4'h0), .pin_out(cp));

  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    @(posedge clk);
    awa <= a;
    wd <= {24'h0, d};
    {awv, wv, brdy} <= 3'h7;
    forever begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
      if (bv) begin
        r = br;
        brdy <= 1'b0;
        break;
      end
    end
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
    @(posedge clk);
    ara <= a;
    {arv, rrdy} <= 2'h3;
    forever begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
      if (rv) begin
        d = rdat[7:0];
        r = rr;
        rrdy <= 1'b0;
        break;
      end
    end
  endtask

  task automatic t_reset;
    logic [7:0] d;
    logic [1:0] r;
    chk("d_pin", dp, OUT_PORT_RESET);
    for (int p = 0; p < NPORT; p++) begin
      chk("oe_n", poe[p], PORT_OEN_RESET);
      bus_rd(CFG_OFF[p], d, r);
      chk("cfg", d, 8'h00);
    end
  endtask

  task automatic t_modes;
    logic [7:0] cf, dv, d, pm;
    logic [1:0] r;
    for (int p = 0; p < NPORT; p++) begin
      for (int m = 0; m < 4; m++) begin
        cf = m[1] ? CFG_MASK[p] : 8'h00;
        // mixed data bit 7 stays clear here so no halt is entered
        dv = m[0] ? (p == 1 ? 8'h7F : 8'hFF) : 8'h00;
        // only the six i/o bits of the mixed port can be driven, and only those are compared at the pins
        pm = (p == 1) ? 8'h3F : DAT_MASK[p];
        bus_wr(DATA_OFF[p], dv, r);
        bus_wr(CFG_OFF[p], m[1] ? 8'hFF : 8'h00, r);
        chk("oe_n", poe[p], ~cf);
        chk("pull", ppu[p], ~cf & dv & DAT_MASK[p]);
        chk("drive", po[p] & ~poe[p], dv & cf);
        bus_rd(CFG_OFF[p], d, r);
        chk("cfg_rd", d, cf);
        repeat (4) @(posedge clk);
        bus_rd(PIN_OFF[p], d, r);
        if (m != 0) chk("pins", d & (p == 1 ? 8'h3F : 8'hFF), (m == 2) ? 8'h00 : pm);
      end
    end
  endtask

  task automatic t_misc;
    logic [7:0] d;
    logic [1:0] r;
    bus_wr(OUT_DATA_OFF, 8'hA5, r);
    chk("d_pin", dp, 8'hA5);
    // a write without its low byte strobe is answered but changes nothing
    strb <= 4'h0;
    bus_wr(OUT_DATA_OFF, 8'h5A, r);
    strb <= 4'h1;
    chk("strb_off", dp, 8'hA5);
    chk("strb_resp", {6'h0, r}, {6'h0, RESP_OKAY});
    ip <= 8'h3C;
    repeat (4) @(posedge clk);
    bus_rd(IN_PIN_OFF, d, r);
    chk("i_pins", d, 8'h3C);
    bus_wr(8'h3C, 8'h55, r);
    chk("bresp", {6'h0, r}, {6'h0, RESP_SLVERR});
    bus_rd(8'h3C, d, r);
    chk("rresp", {6'h0, r}, {6'h0, RESP_SLVERR});
  endtask

  task automatic t_irq;
    logic [7:0] d;
    logic [1:0] r;
    bus_wr(CFG_OFF[1], 8'h00, r);
    bus_wr(DATA_OFF[1], 8'h00, r);
    gxe <= 8'hFF;
    bus_wr(IRQ_MASK_OFF, 8'h01, r);
    bus_wr(IRQ_STATUS_OFF, 8'h07, r);
    chk("irq_off", irq, 1'b0);
    // each pin phase lasts ten cycles, well over one instruction cycle
    gx <= 8'h01;
    repeat (10) @(posedge clk);
    chk("tap", tint, 1'b1);
    chk("irq_on", irq, 1'b1);
    bus_wr(IRQ_STATUS_OFF, 8'h01, r);
    chk("irq_clr", irq, 1'b0);
    bus_wr(IRQ_MASK_OFF, 8'h00, r);
    gx <= 8'h00;
    repeat (10) @(posedge clk);
    gx <= 8'h01;
    repeat (10) @(posedge clk);
    bus_rd(IRQ_STATUS_OFF, d, r);
    chk("status", d, 8'h01);
    chk("irq_mask", irq, 1'b0);
  endtask

  task automatic t_halt;
    logic [7:0] d;
    logic [1:0] r;
    bus_wr(OSC_CTRL_OFF, {6'h0, OSC_RC}, r);
    bus_wr(DATA_OFF[1], G_HALT_MASK, r);
    chk("halt", halt, 1'b1);
    chk("stop", stop, 1'b1);
    gx <= 8'h81;
    repeat (8) @(posedge clk);
    chk("restart", halt, 1'b0);
    bus_rd(IRQ_STATUS_OFF, d, r);
    chk("status", d, 8'h07);
    bus_wr(OSC_CTRL_OFF, {6'h0, OSC_EXTERNAL}, r);
    bus_wr(DATA_OFF[1], G_HALT_MASK, r);
    chk("ext_stop", stop, 1'b0);
    bus_wr(OSC_CTRL_OFF, {6'h0, OSC_CRYSTAL}, r);
    chk("osc_out", osc, 1'b1);
    chk("xtal_stop", stop, 1'b1);
    bus_wr(DATA_OFF[1], 8'h00, r);
    chk("halt_clr", halt, 1'b0);
  endtask

  task automatic t_taps;
    // timer pin phases last ten cycles, over one instruction cycle
    gx <= 8'h08;
    repeat (10) @(posedge clk);
    chk("timer_hi", timer_io_pin, 1'b1);
    gx <= 8'h00;
    repeat (10) @(posedge clk);
    chk("timer_lo", timer_io_pin, 1'b0);
    gx <= 8'h70;
    repeat (4) @(posedge clk);
    chk("serial", {sdi, sck, sdo}, 3'h7);
    // with the clock enable low the synchronised taps must not move
    gx <= 8'h01;
    ce <= 1'b0;
    repeat (6) @(posedge clk);
    chk("ce_hold", tint, 1'b0);
    ce <= 1'b1;
    repeat (4) @(posedge clk);
    chk("ce_run", tint, 1'b1);
  endtask

  task automatic end_sim;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    end_sim();
  end

  initial begin
    rst = 1'b1;
    {awv, wv, brdy, arv, rrdy} = 5'h0;
    ce = 1'b1;
    strb = 4'h1;
    {awa, ara, gx, gxe, ip, wd} = 72'h0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_modes();
    t_misc();
    t_irq();
    t_halt();
    t_taps();
    end_sim();
  end
endmodule

bind gpio_ports gpio_ports_checker i_chk (.CLK_IN(CLK_IN), .RST_IN(RST_IN), .CE_IN(CE_IN),
  .BVALID_OUT(BVALID_OUT), .L_PIN_OUT(L_PIN_OUT), .L_PIN_OE_N_OUT(L_PIN_OE_N_OUT),
  .L_PULLUP_OUT(L_PULLUP_OUT), .G_PIN_IN(G_PIN_IN), .G_PIN_OE_N_OUT(G_PIN_OE_N_OUT),
  .G_PULLUP_OUT(G_PULLUP_OUT), .D_PIN_OUT(D_PIN_OUT),
  .EXTERNAL_INTERRUPT_INPUT_OUT(EXTERNAL_INTERRUPT_INPUT_OUT),
  .HALT_CONTROL_BIT_OUT(HALT_CONTROL_BIT_OUT), .CLOCK_INPUT_STOP_OUT(CLOCK_INPUT_STOP_OUT));
